// ===== logic/gate_ctrl_defs.svh
`ifndef GATE_CTRL_DEFS_SVH
`define GATE_CTRL_DEFS_SVH
// register byte offsets
`define GC_CTRL_OFS 8'h00
`define GC_STATUS_OFS 8'h04
// control field positions and reset value
`define GC_CTRL_STANDBY_BIT 0
`define GC_CTRL_RST 32'h00000000
// status field positions
`define GC_ST_GATE_BIT 0
`define GC_ST_PHASE_LSB 1
`define GC_ST_UNDERVOLTAGE_LOCKOUT_BIT 3
`define GC_ST_OVP_BIT 4
`define GC_ST_TSD_BIT 5
`define GC_ST_EN_BIT 6
`define GC_ST_OC_BIT 7
`define GC_ST_VAR_LSB 8
// clock period and documented times, in ns
`define GC_CLK_NS 20
`define GC_T_OFF_NS 6000
`define GC_T_MINON_NS 200
`define GC_T_EXTOFF_NS 140000
`define GC_T_START_AB_NS 200000
`define GC_T_EN_C_NS 10000
`define GC_T_UNDERVOLTAGE_LOCKOUT_C_NS 140000
// pipeline latency from pin to gate, in cycles
`define GC_SYNC_LAT 5
// derived cycle counts
`define GC_OFF_CYC (`GC_T_OFF_NS / `GC_CLK_NS)
`define GC_MINON_CYC ((`GC_T_MINON_NS + `GC_CLK_NS - 1) / `GC_CLK_NS)
`define GC_EXTOFF_CYC (`GC_T_EXTOFF_NS / `GC_CLK_NS)
`define GC_START_AB_CYC (`GC_T_START_AB_NS / `GC_CLK_NS - `GC_SYNC_LAT)
`define GC_EN_C_CYC (`GC_T_EN_C_NS / `GC_CLK_NS - `GC_SYNC_LAT)
`define GC_UNDERVOLTAGE_LOCKOUT_C_CYC (`GC_T_UNDERVOLTAGE_LOCKOUT_C_NS / `GC_CLK_NS)
`endif

// ===== logic/gate_ctrl_pkg.sv
package gate_ctrl_pkg;
	// threshold source variant
	typedef enum logic [1:0] {VAR_A = 2'h0, VAR_B = 2'h1, VAR_C = 2'h2} variant_t;
	// switching phase, gray along start-on-off-extended off
	typedef enum logic [1:0] {PH_START = 2'h0, PH_ON = 2'h1, PH_OFF = 2'h3, PH_OCOFF = 2'h2} phase_t;
	// analog comparator results and pins
	typedef struct packed {
		logic en;
		logic peakA;
		logic peakB;
		logic peakC;
		logic overCur;
		logic uvloDet;
		logic uvloRel;
		logic ovpDet;
		logic ovpRel;
		logic tsdDet;
		logic tsdRel;
	} ain_t;
	// complete block state
	typedef struct packed {
		ain_t syncA;
		ain_t syncB;
		ain_t syncC;
		ain_t filt;
		logic undervoltage_lockout;
		logic supply_overvoltage_guard;
		logic tsd;
		phase_t phase;
		logic [15:0] cnt;
		logic gate;
		logic discharge;
		logic swStandby;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] rdData;
	} state_t;
endpackage

// ===== logic/fixed_off_time_gate_controller.sv
// What this block does
// R1: variant A ends on when sense exceeds scaled sine
// R2: variant B ends on at 0.3430V threshold
// R3: variant C ends on at 0.3400V threshold
// R4: gate low 6us, then high, repeating
// R5: gate level from comparator, faults and enable
// R6: enable low forces gate low
// R7: enable low is standby, logic only blocks
// R8: A/B first pulse within 200us of enable
// R9: C gate high within 10us of enable
// R10: host dims C with 500Hz-1kHz PWM
// R11: gate held high for minimum on time
// R12: faults or standby cut minimum on short
// R13: over-current forces low, off becomes 140us
// R14: after extended off, resume when sense low
// R15: lockout forces low, resumes on release
// R16: overvoltage discharges supply, forces low, resumes
// R17: thermal 150C forces low, resumes at 130C
// R18: A/B start-up delay at most 200us
// R19: C waits 140us after lockout release
// R20: minimum on time is 0.2us
// R21: variant parameter, intervals as cycle counts
// R22: analog results synchronised before use
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`include "gate_ctrl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module fixed_off_time_gate_controller
	import gate_ctrl_pkg::*;
#(
	parameter variant_t VARIANT = VAR_C,
	parameter logic [15:0] EXT_OFF_CYC = 16'(`GC_EXTOFF_CYC),
	parameter logic [15:0] START_AB_CYC = 16'(`GC_START_AB_CYC),
	parameter logic [15:0] UNDERVOLTAGE_LOCKOUT_C_CYC = 16'(`GC_UNDERVOLTAGE_LOCKOUT_C_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// enable and dimming pin
	input wire logic enableDimmingInput,
	// peak comparator results per threshold source
	input wire logic peakCompSine,
	input wire logic peakCompFixedB,
	input wire logic peakCompFixedC,
	// over-current comparator, sense at or above limit
	input wire logic overCurrentComp,
	// supply and thermal detector levels
	input wire logic lockoutDetectLevel,
	input wire logic lockoutReleaseLevel,
	input wire logic overvoltageDetectLevel,
	input wire logic overvoltageReleaseLevel,
	input wire logic thermalDetect,
	input wire logic thermalRelease,
	// gate drive and supply discharge
	output logic gateDrive,
	output logic supplyDischarge,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	// fixed counts at counter width
	localparam logic [15:0] OFF_CYC = 16'(`GC_OFF_CYC);
	localparam logic [15:0] MINON_CYC = 16'(`GC_MINON_CYC);
	localparam logic [15:0] EN_C_CYC = 16'(`GC_EN_C_CYC);
	// control reset word, only the standby bit is kept in state
	localparam logic [31:0] CTRL_RST = `GC_CTRL_RST;
	// every count loaded while held in start bounds the wait
	// counter is 16 bits, so the default counts fit with margin

	state_t st; // registered state
	state_t next_st; // next state
	ain_t rawIn; // gathered raw inputs
	logic blocked; // enable, standby or fault reason to hold gate low
	logic peak; // selected peak comparator
	// pins arrive from outside this clock, so only the first
	// synchroniser stage reads rawIn

	// selects the comparator for this variant
	// a constant case, so only one comparator is wired through
	function automatic logic peak_sel(input ain_t a);
		case (VARIANT)
			VAR_A: peak_sel = a.peakA; // R1
			VAR_B: peak_sel = a.peakB; // R2
			default: peak_sel = a.peakC; // R3
		endcase
	endfunction

	// delay after enable rise, by variant
	// variant c restarts fast so the dimming duty is followed
	function automatic logic [15:0] en_delay();
		en_delay = (VARIANT == VAR_C) ? EN_C_CYC : START_AB_CYC; // R8 R9 R18
	endfunction

	// delay after lockout release, by variant
	// this count is reloaded every cycle while the lockout latch blocks the gate
	function automatic logic [15:0] undervoltage_lockout_delay();
		undervoltage_lockout_delay = (VARIANT == VAR_C) ? UNDERVOLTAGE_LOCKOUT_C_CYC : START_AB_CYC; // R18 R19
	endfunction

	// register read decode
	// sampled in the address phase, so status reflects that edge
	function automatic logic [31:0] reg_read(input logic [7:0] a, input state_t s);
		reg_read = 32'h00000000;
		case (a)
			`GC_CTRL_OFS: reg_read[`GC_CTRL_STANDBY_BIT] = s.swStandby;
			`GC_STATUS_OFS: begin
				reg_read[`GC_ST_GATE_BIT] = s.gate;
				reg_read[`GC_ST_PHASE_LSB +: 2] = s.phase;
				reg_read[`GC_ST_UNDERVOLTAGE_LOCKOUT_BIT] = s.undervoltage_lockout;
				reg_read[`GC_ST_OVP_BIT] = s.supply_overvoltage_guard;
				reg_read[`GC_ST_TSD_BIT] = s.tsd;
				reg_read[`GC_ST_EN_BIT] = s.filt.en;
				reg_read[`GC_ST_OC_BIT] = s.filt.overCur;
				reg_read[`GC_ST_VAR_LSB +: 2] = VARIANT;
			end
			default: reg_read = 32'h00000000; // unmapped reads zero
		endcase
	endfunction

	// gather pins into one vector
	// one bit per pin, order fixed by the carrier type
	always_comb begin
		rawIn.en = enableDimmingInput;
		rawIn.peakA = peakCompSine;
		rawIn.peakB = peakCompFixedB;
		rawIn.peakC = peakCompFixedC;
		rawIn.overCur = overCurrentComp;
		rawIn.uvloDet = lockoutDetectLevel;
		rawIn.uvloRel = lockoutReleaseLevel;
		rawIn.ovpDet = overvoltageDetectLevel;
		rawIn.ovpRel = overvoltageReleaseLevel;
		rawIn.tsdDet = thermalDetect;
		rawIn.tsdRel = thermalRelease;
	end

	// over-current is no blocking cause, it ends on after minimum on and lengthens the off time
	// standby and fault forcing; R7 only blocks pulses
	assign blocked = !st.filt.en || st.swStandby || st.undervoltage_lockout || st.supply_overvoltage_guard || st.tsd; // R5 R6 R7
	assign peak = peak_sel(st.filt);

	// next state logic
	always_comb begin
		next_st = st;
		// three-stage synchroniser, change taken when stages two and three agree
		// a one-cycle glitch never reaches the filtered copy
		next_st.syncA = rawIn; // R22
		next_st.syncB = st.syncA;
		next_st.syncC = st.syncB;
		for (int i = 0; i < $bits(ain_t); i++) begin
			if (st.syncB[i] == st.syncC[i]) begin
				next_st.filt[i] = st.syncC[i]; // R22
			end
		end
		// fault latches, detect wins over release
		// a latch stays set until its release level is seen,
		// so a short detect still holds the gate low
		if (st.filt.uvloDet) begin
			next_st.undervoltage_lockout = 1'b1; // R15
		end else if (st.filt.uvloRel) begin
			next_st.undervoltage_lockout = 1'b0;
		end
		if (st.filt.ovpDet) begin
			next_st.supply_overvoltage_guard = 1'b1; // R16
		end else if (st.filt.ovpRel) begin
			next_st.supply_overvoltage_guard = 1'b0;
		end
		if (st.filt.tsdDet) begin
			next_st.tsd = 1'b1; // R17
		end else if (st.filt.tsdRel) begin
			next_st.tsd = 1'b0;
		end
		next_st.discharge = next_st.supply_overvoltage_guard; // R16
		// switching phase machine
		// blocking has priority over every phase, so minimum on is cut
		if (blocked) begin
			// held in start, with the delay that fits the cause
			next_st.phase = PH_START; // R12 R15 R16 R17
			if (st.undervoltage_lockout) begin
				next_st.cnt = undervoltage_lockout_delay(); // R19
			end else if (!st.filt.en || st.swStandby) begin
				next_st.cnt = en_delay(); // R8 R9
			end else begin
				next_st.cnt = OFF_CYC;
			end
		end else begin
			case (st.phase)
				PH_START: begin
					// start-up delay counting
					// the delay was loaded by the cause while blocked
					if (st.cnt == 16'h0000) begin
						next_st.phase = PH_ON; // R18
						next_st.cnt = MINON_CYC - 16'h0001;
					end else begin
						next_st.cnt = st.cnt - 16'h0001;
					end
				end
				PH_ON: begin
					// minimum on time ignores comparators
					if (st.cnt != 16'h0000) begin
						next_st.cnt = st.cnt - 16'h0001; // R11 R20
					end else if (st.filt.overCur) begin
						next_st.phase = PH_OCOFF; // R13
						next_st.cnt = EXT_OFF_CYC - 16'h0001;
					end else if (peak) begin
						next_st.phase = PH_OFF; // R1 R2 R3
						next_st.cnt = OFF_CYC - 16'h0001;
					end
				end
				PH_OFF: begin
					// fixed off interval
					if (st.cnt == 16'h0000) begin
						next_st.phase = PH_ON; // R4
						next_st.cnt = MINON_CYC - 16'h0001;
					end else begin
						next_st.cnt = st.cnt - 16'h0001;
					end
				end
				PH_OCOFF: begin
					// extended off, then wait for sense below limit
					// sense is read again after the count, never during it
					if (st.cnt != 16'h0000) begin
						next_st.cnt = st.cnt - 16'h0001; // R13
					end else if (!st.filt.overCur) begin
						next_st.phase = PH_ON; // R14
						next_st.cnt = MINON_CYC - 16'h0001;
					end
				end
				default: begin
					// all four encodings are used, so only an unknown phase lands here; recovers to start
					next_st.phase = PH_START;
					next_st.cnt = OFF_CYC;
				end
			endcase
		end
		// gate is registered from the next phase, so it changes on the same edge as the phase
		next_st.gate = (next_st.phase == PH_ON) && !blocked; // R5
		// bus write data phase
		// write lands at the end of the data phase, when hwdata stands
		next_st.wrPend = 1'b0;
		if (st.wrPend && st.wrAddr == `GC_CTRL_OFS) begin
			next_st.swStandby = hwdata[`GC_CTRL_STANDBY_BIT];
		end
		// bus address phase
		// hreadyout is always high, so no wait state is inserted
		if (hsel && htrans[1] && hready) begin
			next_st.wrPend = hwrite;
			next_st.wrAddr = haddr;
			if (!hwrite) begin
				next_st.rdData = reg_read(haddr, st);
			end
		end
	end

	// state register, async reset loads constants only
	// filters start low, so a high enable pin looks like a rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.undervoltage_lockout <= 1'b1; // locked out until release
			st.cnt <= OFF_CYC;
			st.swStandby <= CTRL_RST[`GC_CTRL_STANDBY_BIT];
		end else begin
			st <= next_st;
		end
	end

	// outputs
	// hrdata holds until the next read address phase is taken
	assign gateDrive = st.gate;
	assign supplyDischarge = st.discharge;
	assign hrdata = st.rdData;
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0; // always okay

	// checks
	// all checks run on the block clock and are off during reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// gate forcing and minimum on
	gate_block_a: assert property (blocked |=> !gateDrive) // R6
		else $error("gate high while blocked");
	fault_cut_a: assert property ((st.undervoltage_lockout || st.supply_overvoltage_guard || st.tsd) && st.phase == PH_ON |=> !gateDrive && st.phase == PH_START) // R12
		else $error("fault did not cut on time");
	minon_load_a: assert property ($rose(st.phase == PH_ON) |-> st.cnt == MINON_CYC - 16'h0001 && gateDrive) // R20
		else $error("minimum on wrong length");
	minon_hold_a: assert property (st.phase == PH_ON && st.cnt != 16'h0000 && !blocked |=> gateDrive) // R11
		else $error("gate dropped during minimum on");
	// fixed and extended off
	off_hold_a: assert property (st.phase == PH_OFF |-> !gateDrive) // R4
		else $error("gate high during fixed off");
	off_end_a: assert property (st.phase == PH_OFF && st.cnt == 16'h0000 && !blocked |=> gateDrive) // R4
		else $error("gate not high after fixed off");
	off_load_a: assert property ($rose(st.phase == PH_OFF) |-> st.cnt == OFF_CYC - 16'h0001 && !gateDrive) // R4
		else $error("fixed off wrong length");
	ext_off_a: assert property ($rose(st.phase == PH_OCOFF) |-> st.cnt == EXT_OFF_CYC - 16'h0001) // R13
		else $error("extended off wrong length");
	oc_resume_a: assert property (st.phase == PH_OCOFF && st.cnt == 16'h0000 && st.filt.overCur |=> !gateDrive) // R14
		else $error("resumed while over current");
	oc_first_a: assert property (st.phase == PH_ON && st.cnt == 16'h0000 && st.filt.overCur && !blocked
		|=> st.phase == PH_OCOFF && !gateDrive) // R13
		else $error("over current did not extend off");

	// comparator, start and synchroniser
	peak_end_a: assert property (st.phase == PH_ON && st.cnt == 16'h0000 && peak && !st.filt.overCur && !blocked
		|=> st.phase == PH_OFF && !gateDrive) // R1
		else $error("peak did not end on period");
	start_max_a: assert property (st.phase == PH_START |-> st.cnt <= en_delay() || st.cnt <= undervoltage_lockout_delay() || st.cnt <= OFF_CYC) // R18
		else $error("start delay too long");
	undervoltage_lockout_c_a: assert property ($fell(st.undervoltage_lockout) |-> st.cnt == undervoltage_lockout_delay()) // R19
		else $error("lockout release delay wrong");
	en_reload_a: assert property (blocked && !st.undervoltage_lockout && (!st.filt.en || st.swStandby) |=> st.cnt == en_delay()) // R9
		else $error("enable delay not loaded");
	sync_filter_a: assert property (((st.filt ^ $past(st.filt)) & ($past(st.syncB) ^ $past(st.syncC))) == '0) // R22
		else $error("filter took a disagreeing bit");

	// supply discharge
	discharge_a: assert property (st.supply_overvoltage_guard |-> supplyDischarge ##1 !gateDrive) // R16
		else $error("discharge not driven");

	// covers for the main scenarios
	gate_rise_c: cover property ($rose(gateDrive));
	ocoff_c: cover property ($rose(st.phase == PH_OCOFF));
	standby_c: cover property ($fell(st.filt.en) ##[1:20] $rose(st.filt.en));
	fault_c: cover property ($rose(st.supply_overvoltage_guard));
	swstby_c: cover property ($rose(st.swStandby));
endmodule
`default_nettype wire

// ===== sim/gate_load_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: power switch and sense resistor, seen as comparator levels
module gate_load_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// gate from the controller, scenario commands
	input wire logic gateDrive,
	input wire logic fastPeak,
	input wire logic shortLoad,
	// comparator levels back to the controller
	output logic peakSense,
	output logic overSense
);
	logic [7:0] ramp; // cycles of coil current rise
	// current ramps while the switch conducts, collapses when off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp <= 8'h00;
		end else begin
			ramp <= gateDrive ? ramp + 8'h01 : 8'h00;
		end
	end
	// peak reached after a ramp, or at once for the noise case
	assign peakSense = gateDrive & (fastPeak | ramp >= 8'h14);
	// shorted load hits the current limit while conducting
	assign overSense = gateDrive & shortLoad;
endmodule
`default_nettype wire

// ===== sim/fixed_off_time_gate_controller_test.sv
`timescale 1ns/1ns
`default_nettype none
module fixed_off_time_gate_controller_test import gate_ctrl_pkg::*;;
	`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
		$display("BAD %s exp %0h got %0h", nm, e, g); end end
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, fastPeak = 1'b0, shortLoad = 1'b0;
	logic [2:0] det = 3'h0, rel = 3'h7; // lockout, overvoltage, thermal
	logic gateDrive, supplyDischarge, peakSense, overSense, hreadyout, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rd;
	int mismatches = 0, checks_done = 0, n;
	// 50 MHz clock
	always #10 clk = ~clk;
	fixed_off_time_gate_controller #(.EXT_OFF_CYC(16'd50), .START_AB_CYC(16'd40), .UNDERVOLTAGE_LOCKOUT_C_CYC(16'd40)) dut_u (
		.clk(clk), .rst_n(rst_n), .enableDimmingInput(en), .peakCompSine(peakSense),
		.peakCompFixedB(peakSense), .peakCompFixedC(peakSense), .overCurrentComp(overSense),
		.lockoutDetectLevel(det[0]), .lockoutReleaseLevel(rel[0]), .overvoltageDetectLevel(det[1]),
		.overvoltageReleaseLevel(rel[1]), .thermalDetect(det[2]), .thermalRelease(rel[2]),
		.gateDrive(gateDrive), .supplyDischarge(supplyDischarge), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp());
	gate_load_model load_u (.clk(clk), .rst_n(rst_n), .gateDrive(gateDrive), .fastPeak(fastPeak),
		.shortLoad(shortLoad), .peakSense(peakSense), .overSense(overSense));
	// counts edges until the gate shows level v, capped at lim
	task automatic waitGate(input logic v, input int lim, output int k);
		k = 0;
		do begin @(posedge clk); k++; end while (gateDrive !== v && k < lim);
	endtask
	// one single ahb-lite word transfer, address then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic t_cycle();
		waitGate(1'b1, 400, n); waitGate(1'b0, 100, n);
		waitGate(1'b1, 400, n); `CHK("offTime", 300, n)
		waitGate(1'b0, 100, n); `CHK("rampOn", 1'b1, n >= 20)
		fastPeak <= 1'b1; waitGate(1'b1, 400, n); waitGate(1'b0, 100, n);
		`CHK("minOn", 1'b1, n >= 10 && n <= 16)
		fastPeak <= 1'b0; $display("test cycle finished");
	endtask
	task automatic t_overcur();
		waitGate(1'b1, 400, n); shortLoad <= 1'b1; waitGate(1'b0, 100, n);
		waitGate(1'b1, 400, n); `CHK("extOff", 1'b1, n >= 50 && n < 300)
		shortLoad <= 1'b0; waitGate(1'b0, 100, n);
		waitGate(1'b1, 400, n); `CHK("resumeOff", 300, n)
		$display("test overcurrent finished");
	endtask
	// fault k raised at the start of an on period, latched, then released
	task automatic t_fault(input int k);
		waitGate(1'b1, 400, n); det[k] <= 1'b1; rel[k] <= 1'b0;
		waitGate(1'b0, 20, n); `CHK("faultCut", 1'b1, n < 10)
		repeat (8) @(posedge clk);
		det[k] <= 1'b0; waitGate(1'b1, 400, n); `CHK("faultHeld", 400, n)
		`CHK("discharge", k == 1, supplyDischarge)
		rel[k] <= 1'b1; waitGate(1'b1, 400, n); `CHK("faultResume", 1'b1, n < 400)
		$display("test fault %0d finished", k);
	endtask
	task automatic t_enable();
		waitGate(1'b1, 400, n); en <= 1'b0; waitGate(1'b0, 20, n);
		`CHK("enOffCut", 1'b1, n < 10)
		waitGate(1'b1, 600, n); `CHK("standbyLow", 600, n)
		en <= 1'b1; waitGate(1'b1, 600, n); `CHK("enRestart", 1'b1, n <= 501)
		$display("test enable finished");
	endtask
	task automatic t_regs();
		bus(1'b1, 8'h00, 32'h1, rd); waitGate(1'b0, 420, n); `CHK("swStandby", 1'b1, n < 420)
		bus(1'b0, 8'h04, 32'h0, rd);
		`CHK("stVariant", VAR_C, rd[9:8])
		`CHK("stGateEn", 2'h2, {rd[6], rd[0]})
		bus(1'b0, 8'h10, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
		bus(1'b1, 8'h00, 32'h0, rd); waitGate(1'b1, 600, n); `CHK("swResume", 1'b1, n < 600)
		$display("test registers finished");
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// main sequence: lockout latched by reset, supply already good
	initial begin
		repeat (20) @(posedge clk);
		`CHK("resetGate", 1'b0, gateDrive)
		rst_n <= 1'b1;
		waitGate(1'b1, 200, n); `CHK("startDelay", 1'b1, n < 200)
		t_cycle();
		t_overcur();
		for (int k = 0; k < 3; k++) t_fault(k);
		t_enable();
		t_regs();
		test_done();
	end
	// watchdog well beyond the expected run of about five thousand cycles
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
